// *** design/drc_top.sv ***
/*
  Dimming reference selection, failsafe discharge sequence and current trim handshake.
  Assumes synchronous inputs from comparators and an analog trim engine result input.
*/
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module drc_top
  import drc_pkg::*;
#(
  parameter int TRIM_COUNT = TRIM_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AWADDR_I,
  input  wire logic        S_AWVALID_I,
  output logic             S_AWREADY_O,
  input  wire logic [31:0] S_WDATA_I,
  input  wire logic [3:0]  S_WSTRB_I,
  input  wire logic        S_WVALID_I,
  output logic             S_WREADY_O,
  output logic [1:0]       S_BRESP_O,
  output logic             S_BVALID_O,
  input  wire logic        S_BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]  S_ARADDR_I,
  input  wire logic        S_ARVALID_I,
  output logic             S_ARREADY_O,
  output logic [31:0]      S_RDATA_O,
  output logic [1:0]       S_RRESP_O,
  output logic             S_RVALID_O,
  input  wire logic        S_RREADY_I,
  // Analog side
  input  wire drc_sense_s  SENSE_I,
  input  wire logic [7:0]  TRIM_RESULT_I,
  output drc_drive_s       DRIVE_O,
  // Interrupt
  output logic             IRQ_O
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]       dim_level_reg;
  logic [1:0]       device_control_reg;
  logic [7:0]       trim_value_reg;
  logic             trim_done_reg;
  logic             trim_busy_reg;
  logic [31:0]      trim_cnt_reg;
  logic [7:0]       trim_result_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  drc_mode_e        mode_reg;
  drc_drive_s       drive_reg;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  logic             wr_fire;
  logic             trim_start_req;
  logic             trim_accept;
  logic             trim_finish;
  logic             uv_off;
  logic             failsafe_in;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clr;
  logic             trim_enable;
  logic             override;

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= IRQ_EN_OFS);
  endfunction

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign S_AWREADY_O = !aw_held_reg && !bvalid_reg;
  assign S_WREADY_O  = !w_held_reg && !bvalid_reg;
  assign S_BVALID_O  = bvalid_reg;
  assign S_BRESP_O   = bresp_reg;
  assign wr_fire     = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
    end else begin
      if (S_AWVALID_I && S_AWREADY_O) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AWADDR_I;
      end
      if (S_WVALID_I && S_WREADY_O) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_WDATA_I;
        w_strb_reg <= S_WSTRB_I;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
      end else if (bvalid_reg && S_BREADY_I) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      dim_level_reg      <= DIM_LEVEL_RST;
      device_control_reg <= 2'b00;
      trim_value_reg     <= TRIM_VALUE_RST;
      irq_en_reg         <= '0;
    end else if (wr_fire && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        DIM_LEVEL_OFS:  dim_level_reg      <= w_data_reg[7:0];
        DEV_CTRL_OFS:   device_control_reg <= w_data_reg[1:0];
        TRIM_VALUE_OFS: trim_value_reg     <= w_data_reg[7:0];
        IRQ_EN_OFS:     irq_en_reg         <= w_data_reg[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign override    = device_control_reg[CTRL_OVERRIDE_BIT];
  assign trim_enable = device_control_reg[CTRL_TRIM_EN_BIT];

  // ----------------------------------------
  // Trim routine
  // ----------------------------------------
  assign trim_start_req = wr_fire && w_strb_reg[0] && (aw_addr_reg == TRIM_CTRL_OFS)
                          && w_data_reg[TRIM_START_BIT];
  // Start needs trim enable and no routine running
  assign trim_accept = trim_start_req && trim_enable && !trim_busy_reg; // R13 R19
  assign trim_finish = trim_busy_reg && (trim_cnt_reg == 32'h0000_0001);

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      trim_busy_reg   <= 1'b0;
      trim_cnt_reg    <= 32'h0000_0000;
      trim_done_reg   <= 1'b0;
      trim_result_reg <= TRIM_VALUE_RST;
    end else begin
      if (trim_accept) begin
        trim_busy_reg <= 1'b1;
        trim_cnt_reg  <= 32'(TRIM_COUNT); // R11
        trim_done_reg <= 1'b0; // R18
      end else if (trim_finish) begin
        trim_busy_reg   <= 1'b0;
        trim_cnt_reg    <= 32'h0000_0000;
        trim_done_reg   <= 1'b1; // R11
        trim_result_reg <= TRIM_RESULT_I;
      end else if (trim_busy_reg) begin
        trim_cnt_reg <= trim_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Failsafe sequence
  // ----------------------------------------
  assign failsafe_in = SENSE_I.failsafe_request;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      mode_reg <= ST_NORMAL;
    end else begin
      unique case (mode_reg)
        ST_NORMAL:    if (failsafe_in) mode_reg <= ST_DISCHARGE; // R4
        ST_DISCHARGE: begin
          if (!failsafe_in) begin
            mode_reg <= ST_NORMAL; // R4
          end else if (SENSE_I.short_reached) begin
            mode_reg <= ST_FAILSAFE; // R7
          end
        end
        ST_FAILSAFE:  if (!failsafe_in) mode_reg <= ST_NORMAL; // R4
      endcase
    end
  end

  // ----------------------------------------
  // Reference and gate drive
  // ----------------------------------------
  // Internal supply monitor is masked whenever mode_reg has left ST_NORMAL
  assign uv_off = !SENSE_I.gate_supply_external_ok
                  || (!SENSE_I.gate_supply_internal_ok && mode_reg == ST_NORMAL); // R15 R16

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      drive_reg <= '0;
    end else begin
      drive_reg.discharge_delay <= DISCH_DELAY_DFLT; // R7
      drive_reg.discharge       <= (mode_reg == ST_DISCHARGE); // R7
      drive_reg.set_pin_dimming <= override || (mode_reg != ST_NORMAL); // R6
      if (mode_reg != ST_NORMAL) begin
        drive_reg.reference <= SENSE_I.set_level; // R6
      end else if (override) begin
        drive_reg.reference <= (SENSE_I.set_level < dim_level_reg) ?
                               SENSE_I.set_level : dim_level_reg; // R2
      end else begin
        drive_reg.reference <= dim_level_reg; // R1
      end
      drive_reg.trim_applied <= trim_enable ? trim_result_reg : trim_value_reg; // R12 R13
      drive_reg.gate_enable  <= SENSE_I.brightness_gate && !uv_off; // R17 R15
      // Regulation during failsafe waits for the discharge to finish
      drive_reg.switch_enable <= SENSE_I.brightness_gate && SENSE_I.enable_uvlo && !uv_off
                                 && (mode_reg != ST_DISCHARGE); // R5 R8
    end
  end

  assign DRIVE_O = drive_reg;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_events = {uv_off, (mode_reg == ST_DISCHARGE) && SENSE_I.short_reached,
                       trim_finish};
  assign irq_clr    = (wr_fire && w_strb_reg[0] && aw_addr_reg == IRQ_CLR_OFS) ?
                      w_data_reg[IRQ_W-1:0] : '0;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      irq_stat_reg <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_events;
    end
  end

  assign IRQ_O = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign S_ARREADY_O = !rvalid_reg;
  assign S_RVALID_O  = rvalid_reg;
  assign S_RDATA_O   = rdata_reg;
  assign S_RRESP_O   = rresp_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end else if (S_ARVALID_I && S_ARREADY_O) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= mapped(S_ARADDR_I) ? 2'b00 : 2'b10;
      unique case (S_ARADDR_I)
        DIM_LEVEL_OFS:  rdata_reg <= {24'h00_0000, dim_level_reg};
        DEV_CTRL_OFS:   rdata_reg <= {30'h0000_0000, device_control_reg};
        TRIM_CTRL_OFS:  rdata_reg <= {30'h0000_0000, trim_done_reg, trim_busy_reg};
        TRIM_VALUE_OFS: rdata_reg <= {24'h00_0000,
                                      trim_enable ? trim_result_reg : trim_value_reg}; // R12 R13
        STATUS_OFS:     rdata_reg <= {29'h0000_0000, uv_off, 2'(mode_reg)};
        IRQ_STAT_OFS:   rdata_reg <= {29'h0000_0000, irq_stat_reg};
        IRQ_EN_OFS:     rdata_reg <= {29'h0000_0000, irq_en_reg};
        default:        rdata_reg <= 32'h0000_0000;
      endcase
    end else if (rvalid_reg && S_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// *** design/drc_pkg.sv ***
/*
  Package for the dimming reference and current trim control block.
  Holds register offsets, field positions, reset values, timing counts and carrier types.
  Assumes a 250 MHz core clock and an AXI4-Lite master with 32-bit data.
*/
// Behaviour
// R1: Override clear and failsafe low: reference comes from the 8-bit dim level value.
// R2: Override set: reference is the lower of set-pin level and dim level value.
// R3: Host programs dim level 240 for full-range set-pin dimming under override.
// R4: Failsafe state is held only while failsafe request input is high.
// R5: Switching needs brightness gate and enable/uvlo high, also in failsafe state.
// R6: In failsafe or with override set, dimming follows the set pin.
// R7: Entering failsafe runs fast discharge to short threshold with default discharge delay.
// R8: After discharge, regulate at set-pin level only if brightness gate is high.
// R9: Host keeps output current zero during trim: gate low, load disconnected.
// R10: Host sets trim enable, then trim start, quickly.
// R11: Trim routine runs about 200 us, then raises trim done flag.
// R12: Trim enable high: routine result is applied and read back.
// R13: Trim enable low: host value applied and read back; starts ignored.
// R14: Host repeats trim periodically or loads a stored result.
// R15: Gate drivers off when internal or external gate supply is undervoltage.
// R16: In failsafe, internal gate supply undervoltage is ignored.
// R17: Main gate drivers follow the brightness gate input.
// R18: Accepted trim start clears trim done flag.
// R19: Trim start ignored while routine runs; one done flag per accepted start.
package drc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] DIM_LEVEL_OFS   = 8'h00;
  localparam logic [7:0] DEV_CTRL_OFS    = 8'h04;
  localparam logic [7:0] TRIM_CTRL_OFS   = 8'h08;
  localparam logic [7:0] TRIM_VALUE_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS      = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS    = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS     = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS      = 8'h1C;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int          CTRL_OVERRIDE_BIT = 0;
  localparam int          CTRL_TRIM_EN_BIT  = 1;
  localparam int          TRIM_START_BIT    = 0;
  localparam int          TRIM_DONE_BIT     = 1;
  localparam int          TRIM_W            = 8;
  localparam logic [7:0]  DIM_LEVEL_RST     = 8'h00;
  localparam logic [7:0]  TRIM_VALUE_RST    = 8'h00;
  localparam logic [7:0]  DISCH_DELAY_DFLT  = 8'h03;
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_TRIM_DONE     = 0;
  localparam int          IRQ_FAILSAFE      = 1;
  localparam int          IRQ_UV            = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int TRIM_TIME_US   = 200;
  localparam int TRIM_CYCLES    = TRIM_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_NORMAL, ST_DISCHARGE, ST_FAILSAFE} drc_mode_e;

  typedef struct packed {
    logic [7:0] set_level;
    logic       brightness_gate;
    logic       enable_uvlo;
    logic       gate_supply_internal_ok;
    logic       gate_supply_external_ok;
    logic       failsafe_request;
    logic       short_reached;
  } drc_sense_s;

  typedef struct packed {
    logic [7:0] reference;
    logic [7:0] trim_applied;
    logic [7:0] discharge_delay;
    logic       set_pin_dimming;
    logic       discharge;
    logic       switch_enable;
    logic       gate_enable;
  } drc_drive_s;
endpackage

// *** verification/drc_top_asserts.sv ***
/* Checker for drc_top: failsafe, switching and bus-hold relations.
   Bound to drc_top below; sees only its ports. */
`timescale 1ns/1ps
module drc_chk
  import drc_pkg::*;
#(
  parameter int TRIM_COUNT = 20
) (
  // Clock and reset
  input wire logic       REF_CLK_I,
  input wire logic       NRST_I,
  // Bus responses
  input wire logic       S_RVALID_O,
  input wire logic       S_RREADY_I,
  input wire logic       S_BVALID_O,
  input wire logic       S_BREADY_I,
  // Analog side
  input wire drc_sense_s SENSE_I,
  input wire drc_drive_s DRIVE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  // ----
  // Sequences
  // ----
  sequence s_enter;
    $rose(SENSE_I.failsafe_request) && !SENSE_I.short_reached ##1 SENSE_I.failsafe_request;
  endsequence
  sequence s_lh_ready;
    SENSE_I.failsafe_request && SENSE_I.short_reached && SENSE_I.brightness_gate
      && SENSE_I.enable_uvlo && SENSE_I.gate_supply_external_ok;
  endsequence
  // ----
  // Assertions
  // ----
  AST_GATE_FOLLOW: assert property (DRIVE_O.gate_enable |-> $past(SENSE_I.brightness_gate))
    else $error("gate enable without brightness gate");
  AST_SW_INPUTS: assert property (DRIVE_O.switch_enable |->
    $past(SENSE_I.brightness_gate) && $past(SENSE_I.enable_uvlo))
    else $error("switching without gate and enable inputs");
  AST_EXT_UV: assert property (!SENSE_I.gate_supply_external_ok [*2] |=>
    !DRIVE_O.switch_enable) else $error("switching under external supply uv");
  AST_INT_UV: assert property ((!SENSE_I.gate_supply_internal_ok
    && !SENSE_I.failsafe_request) [*3] |=> !DRIVE_O.switch_enable)
    else $error("switching under internal supply uv");
  AST_LH_RUN: assert property (s_lh_ready [*5] |=>
    DRIVE_O.switch_enable && DRIVE_O.set_pin_dimming) else $error("failsafe not regulating");
  AST_DISCH: assert property (s_enter |=> DRIVE_O.discharge
    && DRIVE_O.discharge_delay == DISCH_DELAY_DFLT) else $error("no discharge on entry");
  AST_DISCH_END: assert property (DRIVE_O.discharge && SENSE_I.short_reached
    && SENSE_I.failsafe_request && $past(SENSE_I.failsafe_request)
    ##1 SENSE_I.failsafe_request |=> !DRIVE_O.discharge)
    else $error("discharge past short threshold");
  AST_RHOLD: assert property (S_RVALID_O && !S_RREADY_I |=> S_RVALID_O)
    else $error("read response dropped");
  AST_BHOLD: assert property (S_BVALID_O && !S_BREADY_I |=> S_BVALID_O)
    else $error("write response dropped");
endmodule
bind drc_top drc_chk #(.TRIM_COUNT(TRIM_COUNT)) drc_chk_i (.REF_CLK_I(REF_CLK_I),
  .NRST_I(NRST_I), .S_RVALID_O(S_RVALID_O), .S_RREADY_I(S_RREADY_I), .S_BVALID_O(S_BVALID_O),
  .S_BREADY_I(S_BREADY_I), .SENSE_I(SENSE_I), .DRIVE_O(DRIVE_O));

// *** verification/drc_host.sv ***
/* Host controller model: AXI4-Lite master with write and read tasks.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module drc_host (
  // Clock
  input  wire logic        clk_i,
  // Slave answers
  input  wire logic        awready_i,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic [31:0] rdata_i,
  // Requests
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  output logic             rready_o
);
  initial {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
  initial {araddr_o, arvalid_o, rready_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    @(posedge clk_i);
    aw = 1'b0;
    w = 1'b0;
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    // Each channel is released on its own handshake edge
    while (!(aw && w)) begin
      @(posedge clk_i);
      if (awready_i) aw = 1'b1;
      if (wready_i) w = 1'b1;
      if (aw) awvalid_o <= 1'b0;
      if (w) wvalid_o <= 1'b0;
    end
    while (bvalid_i !== 1'b1) @(posedge clk_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    while (rvalid_i !== 1'b1) @(posedge clk_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

// *** verification/tb.sv ***
/* Self-checking bench for drc_top with a host model on the register bus.
   Trim count shortened to 20 cycles; expectations derive from it. */
`timescale 1ns/1ps
module tb
  import drc_pkg::*;
;
  localparam int TC = 20;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  drc_sense_s  sense = '{8'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  drc_drive_s  drv;
  logic        irq;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [1:0]  b_resp, r_resp;
  logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  drc_top #(.TRIM_COUNT(TC)) drc_top_i (.REF_CLK_I(clk), .NRST_I(nrst), .S_AWADDR_I(aw_addr),
    .S_AWVALID_I(aw_v), .S_AWREADY_O(aw_r), .S_WDATA_I(w_data), .S_WSTRB_I(4'hF),
    .S_WVALID_I(w_v), .S_WREADY_O(w_r), .S_BRESP_O(b_resp), .S_BVALID_O(b_v),
    .S_BREADY_I(b_r), .S_ARADDR_I(ar_addr), .S_ARVALID_I(ar_v), .S_ARREADY_O(ar_r),
    .S_RDATA_O(r_data), .S_RRESP_O(r_resp), .S_RVALID_O(r_v), .S_RREADY_I(r_r),
    .SENSE_I(sense), .TRIM_RESULT_I(8'h3C), .DRIVE_O(drv), .IRQ_O(irq));
  drc_host drc_host_i (.clk_i(clk), .awready_i(aw_r), .wready_i(w_r), .bvalid_i(b_v),
    .bresp_i(b_resp), .arready_i(ar_r), .rvalid_i(r_v), .rresp_i(r_resp), .rdata_i(r_data),
    .awaddr_o(aw_addr), .awvalid_o(aw_v), .wdata_o(w_data), .wvalid_o(w_v), .bready_o(b_r),
    .araddr_o(ar_addr), .arvalid_o(ar_v), .rready_o(r_r));
  // ----
  // Helpers
  // ----
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic [1:0] r;
    drc_host_i.wr(a, d, r);
    check("bresp", 32'(r), 32'(er));
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'b00);
    logic [31:0] d;
    logic [1:0]  r;
    drc_host_i.rd(a, d, r);
    check(n, d, e);
    check("rresp", 32'(r), 32'(er));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    foreach (ofs[i]) rchk("reset_val", ofs[i], 32'h0);
    rchk("unmapped", 8'h20, 32'h0, 2'b10);
    w(8'h22, 32'h1, 2'b10);
    w(IRQ_STAT_OFS, 32'h7);
    rchk("ro_stat", IRQ_STAT_OFS, 32'h0);
  endtask
  task automatic t_ref();
    w(DIM_LEVEL_OFS, 32'hA5);
    tick(2);
    check("ref_dim", drv.reference, 8'hA5);
    @(posedge clk);
    sense.set_level <= 8'h80;
    w(DIM_LEVEL_OFS, 32'hF0);
    w(DEV_CTRL_OFS, 32'h1);
    tick(2);
    check("ref_pin", drv.reference, 8'h80);
    check("pin_dim", drv.set_pin_dimming, 1'b1);
    @(posedge clk);
    sense.set_level <= 8'hFF;
    tick(3);
    check("ref_dac", drv.reference, 8'hF0);
    w(DEV_CTRL_OFS, 32'h0);
  endtask
  task automatic t_lh();
    @(posedge clk);
    sense.gate_supply_internal_ok <= 1'b0;
    sense.failsafe_request <= 1'b1;
    tick(3);
    check("disch", drv.discharge, 1'b1);
    check("disch_dly", drv.discharge_delay, DISCH_DELAY_DFLT);
    rchk("mode_dis", STATUS_OFS, 32'h1);
    @(posedge clk);
    sense.short_reached <= 1'b1;
    tick(4);
    check("lh_sw", drv.switch_enable, 1'b1);
    check("lh_ref", drv.reference, 8'hFF);
    check("lh_pin", drv.set_pin_dimming, 1'b1);
    rchk("mode_fs", STATUS_OFS, 32'h2);
    @(posedge clk);
    sense.brightness_gate <= 1'b0;
    tick(3);
    check("lh_gate", drv.switch_enable, 1'b0);
    check("gate_off", drv.gate_enable, 1'b0);
    @(posedge clk);
    sense.brightness_gate <= 1'b1;
    sense.gate_supply_external_ok <= 1'b0;
    tick(3);
    check("ext_uv", drv.switch_enable, 1'b0);
    @(posedge clk);
    sense.gate_supply_external_ok <= 1'b1;
    sense.failsafe_request <= 1'b0;
    sense.short_reached <= 1'b0;
    tick(4);
    check("int_uv", drv.switch_enable, 1'b0);
    rchk("uv_stat", STATUS_OFS, 32'h4);
    @(posedge clk);
    sense.gate_supply_internal_ok <= 1'b1;
    tick(3);
    check("sw_on", drv.switch_enable, 1'b1);
    check("gate_on", drv.gate_enable, 1'b1);
    @(posedge clk);
    sense.enable_uvlo <= 1'b0;
    tick(3);
    check("en_uvlo", drv.switch_enable, 1'b0);
    check("en_gate", drv.gate_enable, 1'b1);
    @(posedge clk);
    sense.enable_uvlo <= 1'b1;
    rchk("irq_ev", IRQ_STAT_OFS, 32'h6);
    w(IRQ_CLR_OFS, 32'h6);
  endtask
  task automatic t_trim();
    int t0;
    w(TRIM_VALUE_OFS, 32'h5A);
    w(TRIM_CTRL_OFS, 32'h1);
    rchk("start_off", TRIM_CTRL_OFS, 32'h0);
    rchk("trim_host", TRIM_VALUE_OFS, 32'h5A);
    #1;
    check("app_host", drv.trim_applied, 8'h5A);
    @(posedge clk);
    sense.brightness_gate <= 1'b0;
    w(IRQ_EN_OFS, 32'h1);
    w(DEV_CTRL_OFS, 32'h2);
    w(TRIM_CTRL_OFS, 32'h1);
    t0 = cyc;
    // A restart while busy would push the done edge past the window
    repeat (8) @(posedge clk);
    w(TRIM_CTRL_OFS, 32'h1);
    while (irq !== 1'b1 && cyc - t0 < 4 * TC) @(posedge clk);
    check("trim_time", 32'(cyc - t0 >= TC - 3 && cyc - t0 <= TC + 2), 32'h1);
    rchk("done", TRIM_CTRL_OFS, 32'h2);
    rchk("trim_res", TRIM_VALUE_OFS, 32'h3C);
    #1;
    check("app_res", drv.trim_applied, 8'h3C);
    w(IRQ_EN_OFS, 32'h0);
    #1;
    check("irq_mask", irq, 1'b0);
    w(IRQ_CLR_OFS, 32'h1);
    rchk("irq_clr", IRQ_STAT_OFS, 32'h0);
    w(TRIM_CTRL_OFS, 32'h1);
    rchk("done_clr", TRIM_CTRL_OFS, 32'h1);
    w(DEV_CTRL_OFS, 32'h0);
    rchk("trim_back", TRIM_VALUE_OFS, 32'h5A);
    tick(2);
    check("app_back", drv.trim_applied, 8'h5A);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ref();
    t_lh();
    t_trim();
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
